// ### core/sffpa_pkg.sv
/*
  Shared constants and carriers for the switch frame filter and port
  authentication block, plus the per-entry access-control matcher.
  Assumes one core clock and a frame summary presented by the parser.
*/
package sffpa_pkg;
  // Register offsets on the byte-wide control port
  localparam logic [7:0] SFFPA_OFS_GC15 = 8'h0F;
  localparam logic [7:0] SFFPA_OFS_GC16 = 8'h10;
  localparam logic [7:0] SFFPA_OFS_GC17 = 8'h11;
  localparam logic [7:0] SFFPA_OFS_GC18 = 8'h12;
  localparam logic [7:0] SFFPA_OFS_RSV_PAGE = 8'h13;
  localparam logic [7:0] SFFPA_OFS_PORT_CTRL5 = 8'h20;
  localparam logic [7:0] SFFPA_OFS_MAC0 = 8'h68;
  localparam logic [7:0] SFFPA_OFS_RULE_BASE = 8'h80;
  // Field positions
  localparam int SFFPA_BIT_SELF_EN = 6;
  localparam int SFFPA_BIT_FILT_EN = 5;
  localparam int SFFPA_BIT_ACL_EN = 2;
  // Reset values
  localparam logic [7:0] SFFPA_RST_GC = 8'h1F;
  localparam logic [7:0] SFFPA_RST_RSV_PAGE = 8'h00;
  localparam logic [7:0] SFFPA_RST_ZERO = 8'h00;
  // Fixed numbers
  localparam int SFFPA_PORTS = 5;
  localparam int SFFPA_RULES = 16;
  localparam int SFFPA_RULE_BYTES = 8;
  localparam logic [4:0] SFFPA_CPU_MAP = 5'h10;
  localparam logic [47:0] SFFPA_EAPOL_DA = 48'h0180C2000003;
  localparam logic [31:0] SFFPA_RSV_PREFIX = 32'h0180C200;
  localparam logic [7:0] SFFPA_RSV_LOW = 8'h03;

  typedef enum logic [1:0] {
    SFFPA_AUTH_PASS = 2'b00,
    SFFPA_AUTH_BLOCK = 2'b01,
    SFFPA_AUTH_UNDEF = 2'b10,
    SFFPA_AUTH_TRAP = 2'b11
  } sffpa_auth_type;

  typedef enum logic [1:0] {
    SFFPA_LAYER_OFF = 2'b00,
    SFFPA_LAYER_L2 = 2'b01,
    SFFPA_LAYER_L3 = 2'b10,
    SFFPA_LAYER_L4 = 2'b11
  } sffpa_layer_type;

  // Frame summary from the parser and lookup engine
  typedef struct packed {
    logic valid;
    logic [2:0] src_port;
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] ethertype;
    logic [31:0] ip_src;
    logic [31:0] ip_dst;
    logic [15:0] l4_src;
    logic [15:0] l4_dst;
    logic [7:0] protocol;
    logic unknown_uc;
    logic unknown_mc;
    logic unknown_vid;
    logic unknown_ipmc;
    logic [4:0] lookup_map;
  } sffpa_frame_type;

  // Forwarding decision back to the queue manager
  typedef struct packed {
    logic valid;
    logic [4:0] fwd_map;
    logic to_cpu;
    logic acl_hit;
  } sffpa_decision_type;
endpackage : sffpa_pkg

`timescale 1ns/1ps
// One access-control entry tested against the frame summary
module sffpa_rule_match
  import sffpa_pkg::*;
(
  input wire sffpa_frame_type frame,
  input wire logic [23:0] cfg,
  output logic hit
);
  logic [15:0] sel;
  logic [1:0] enb;
  logic sd;
  logic eq;

  // Byte 0 mode/enable/select/compare, bytes 1-2 value
  always_comb begin
    enb = cfg[3:2];
    sd = cfg[4];
    eq = cfg[5];
    case (sffpa_layer_type'(cfg[1:0])) // see RULE19
      SFFPA_LAYER_L2: sel = enb[1] ? frame.ethertype : (sd ? frame.sa[15:0] : frame.da[15:0]);
      SFFPA_LAYER_L3: sel = sd ? frame.ip_src[15:0] : frame.ip_dst[15:0];
      SFFPA_LAYER_L4: sel = enb[1] ? (sd ? frame.l4_src : frame.l4_dst) : {8'h00, frame.protocol};
      default: sel = 16'h0000;
    endcase
    // Disabled entries never hit, whatever the compare sense
    hit = (cfg[1:0] != 2'b00) && ((sel == cfg[23:8]) == eq);
  end
endmodule : sffpa_rule_match

// ### core/sffpa_top.sv
/*
  Forwarding-path filter: global unknown-frame and self-address filters,
  port authentication trapping, per-port auth modes and ACL rule sets.
  Assumes a frame summary from same-clock lookup logic, one decision a
  cycle later, and a same-clock byte-wide register port.
*/
// Our own choices: the placing of the registers and the address-and-strobe port.
// Contract
// RULE1: Self-address filter enable drops frames sourced from own MAC at egress.
// RULE2: Unknown unicast filter enabled forwards only to its five-bit map.
// RULE3: Unknown multicast filter enabled forwards only to its five-bit map.
// RULE4: Unknown VLAN ID filter enabled forwards only to its five-bit map.
// RULE5: Unknown IP multicast filter enabled forwards only to its map.
// RULE6: All these filters are switch-wide, one setting for every port.
// RULE7: Authentication frames detected by destination address go to CPU port.
// RULE8: Pass mode 00 treats port as always authorised.
// RULE9: Pass mode with ACL: misses pass, hits take the rule action.
// RULE10: Block mode 01 blocks all incoming frames without source check.
// RULE11: Block mode with ACL blocks everything except rule hits.
// RULE12: Software moves port to pass after success and keeps reserved maps open.
// RULE13: Trap mode 11 redirects all incoming frames to the CPU port.
// RULE14: Trap mode with ACL sends misses to the CPU, not dropped.
// RULE15: Port control five: bit 2 ACL enable, bits 1:0 auth mode.
// RULE16: Frames tested against ordered entries; entries may cascade together.
// RULE17: Match on MAC addresses, Ethertype, IP addresses, L4 port and protocol; the code compares only the low 16 bits of each address.
// RULE18: Each entry has matching, action and processing parts.
// RULE19: Entry mode selects disabled, L2, L3 or L4 matching.
// RULE20: Set matches when all members match; lowest first rule index wins.
// RULE21: Filter disabled means normal flooding, port map ignored.
// RULE22: Undefined auth mode 10 behaves like pass mode.
`timescale 1ns/1ps
module sffpa_top
  import sffpa_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sffpa_frame_type frame_in,
  output sffpa_decision_type decision
);
  logic [7:0] gc_q [4];
  logic [7:0] gc_d [4];
  logic [7:0] mac_q [6];
  logic [7:0] mac_d [6];
  logic [7:0] pctl_q [SFFPA_PORTS];
  logic [7:0] pctl_d [SFFPA_PORTS];
  logic [7:0] rule_q [SFFPA_RULES*SFFPA_RULE_BYTES];
  logic [7:0] rule_d [SFFPA_RULES*SFFPA_RULE_BYTES];
  logic [7:0] rsv_page_q;
  logic [7:0] rsv_page_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  sffpa_decision_type dec_q;
  sffpa_decision_type dec_d;

  // Register writes; a read has no side effect
  always_comb begin
    gc_d = gc_q;
    mac_d = mac_q;
    pctl_d = pctl_q;
    rule_d = rule_q;
    rsv_page_d = rsv_page_q;
    if (reg_wr) begin
      if (reg_addr >= SFFPA_OFS_GC15 && reg_addr <= SFFPA_OFS_GC18) begin
        gc_d[2'(reg_addr - SFFPA_OFS_GC15)] = reg_wdata; // see RULE6
      end else if (reg_addr == SFFPA_OFS_RSV_PAGE) begin
        rsv_page_d = reg_wdata;
      end else if (reg_addr >= SFFPA_OFS_MAC0 && reg_addr < SFFPA_OFS_MAC0 + 8'h06) begin
        mac_d[3'(reg_addr - SFFPA_OFS_MAC0)] = reg_wdata;
      end else if (reg_addr >= SFFPA_OFS_PORT_CTRL5
                   && reg_addr < SFFPA_OFS_PORT_CTRL5 + 8'h05) begin
        pctl_d[3'(reg_addr - SFFPA_OFS_PORT_CTRL5)] = {5'h00, reg_wdata[2:0]}; // see RULE15
      end else if (reg_addr >= SFFPA_OFS_RULE_BASE) begin
        rule_d[7'(reg_addr - SFFPA_OFS_RULE_BASE)] = reg_wdata; // see RULE18
      end
    end
  end

  // Read data for the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      if (reg_addr >= SFFPA_OFS_GC15 && reg_addr <= SFFPA_OFS_GC18) begin
        rdata_d = gc_q[2'(reg_addr - SFFPA_OFS_GC15)];
      end else if (reg_addr == SFFPA_OFS_RSV_PAGE) begin
        rdata_d = rsv_page_q;
      end else if (reg_addr >= SFFPA_OFS_MAC0 && reg_addr < SFFPA_OFS_MAC0 + 8'h06) begin
        rdata_d = mac_q[3'(reg_addr - SFFPA_OFS_MAC0)];
      end else if (reg_addr >= SFFPA_OFS_PORT_CTRL5
                   && reg_addr < SFFPA_OFS_PORT_CTRL5 + 8'h05) begin
        rdata_d = pctl_q[3'(reg_addr - SFFPA_OFS_PORT_CTRL5)];
      end else if (reg_addr >= SFFPA_OFS_RULE_BASE) begin
        rdata_d = rule_q[7'(reg_addr - SFFPA_OFS_RULE_BASE)];
      end
    end
  end

  // Register file storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) gc_q[i] <= SFFPA_RST_GC;
      for (int i = 0; i < 6; i++) mac_q[i] <= SFFPA_RST_ZERO;
      for (int i = 0; i < SFFPA_PORTS; i++) pctl_q[i] <= SFFPA_RST_ZERO;
      for (int i = 0; i < SFFPA_RULES*SFFPA_RULE_BYTES; i++) rule_q[i] <= SFFPA_RST_ZERO;
      rsv_page_q <= SFFPA_RST_RSV_PAGE;
      rdata_q <= SFFPA_RST_ZERO;
    end else begin
      gc_q <= gc_d;
      mac_q <= mac_d;
      pctl_q <= pctl_d;
      rule_q <= rule_d;
      rsv_page_q <= rsv_page_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Per-entry matchers, one per table row
  logic [SFFPA_RULES-1:0] rule_hit;
  for (genvar r = 0; r < SFFPA_RULES; r++) begin : g_rule
    sffpa_rule_match u_match (
      .frame(frame_in),
      .cfg({rule_q[r*8+2], rule_q[r*8+1], rule_q[r*8]}),
      .hit(rule_hit[r])
    ); // see RULE17
  end

  // Rule-set arbitration: AND of members, lowest first index wins
  logic acl_any;
  logic [3:0] acl_first_rule_index;
  logic [15:0] cascaded_rule_group_mask;
  logic [3:0] set_first_rule_index;
  always_comb begin
    acl_any = 1'b0;
    acl_first_rule_index = 4'hF;
    for (int s = 0; s < SFFPA_RULES; s++) begin
      cascaded_rule_group_mask = {rule_q[s*8+6], rule_q[s*8+5]};
      set_first_rule_index = rule_q[s*8+4][3:0];
      if (cascaded_rule_group_mask != 16'h0000
          && (cascaded_rule_group_mask & ~rule_hit) == 16'h0000) begin // see RULE16
        if (!acl_any || set_first_rule_index < acl_first_rule_index) begin // see RULE20
          acl_any = 1'b1;
          acl_first_rule_index = set_first_rule_index;
        end
      end
    end
  end

  // Action of the winning set comes from its first rule's entry
  logic [4:0] act_fwd;
  logic [1:0] act_mm;
  always_comb begin
    act_fwd = rule_q[{acl_first_rule_index, 3'h3}][4:0];
    act_mm = rule_q[{acl_first_rule_index, 3'h3}][6:5];
  end

  // Frame decision path
  logic [4:0] base_map;
  logic [4:0] acl_map;
  logic [4:0] final_map;
  logic port_acl_en;
  logic acl_hit;
  logic is_auth;
  logic self_src;
  logic to_cpu;
  sffpa_auth_type mode;
  always_comb begin
    // Unknown-class maps replace the lookup result only when enabled
    base_map = frame_in.lookup_map; // see RULE21
    if (frame_in.unknown_vid && gc_q[2][SFFPA_BIT_FILT_EN]) begin
      base_map = gc_q[2][4:0]; // see RULE4
    end else if (frame_in.unknown_ipmc && gc_q[3][SFFPA_BIT_FILT_EN]) begin
      base_map = gc_q[3][4:0]; // see RULE5
    end else if (frame_in.unknown_mc && gc_q[1][SFFPA_BIT_FILT_EN]) begin
      base_map = gc_q[1][4:0]; // see RULE3
    end else if (frame_in.unknown_uc && gc_q[0][SFFPA_BIT_FILT_EN]) begin
      base_map = gc_q[0][4:0]; // see RULE2
    end
    // Authentication frames by destination, standard or reserved page
    is_auth = (frame_in.da == SFFPA_EAPOL_DA)
              || (frame_in.da == {SFFPA_RSV_PREFIX, rsv_page_q, SFFPA_RSV_LOW}); // see RULE7
    port_acl_en = 1'b0;
    mode = SFFPA_AUTH_PASS;
    if (frame_in.src_port < 3'(SFFPA_PORTS)) begin
      port_acl_en = pctl_q[frame_in.src_port][SFFPA_BIT_ACL_EN]; // see RULE15
      mode = sffpa_auth_type'(pctl_q[frame_in.src_port][1:0]);
    end
    acl_hit = port_acl_en && acl_any;
    case (act_mm)
      2'b01: acl_map = base_map | act_fwd;
      2'b10: acl_map = base_map & act_fwd;
      2'b11: acl_map = act_fwd;
      default: acl_map = base_map;
    endcase
    to_cpu = 1'b0;
    case (mode)
      SFFPA_AUTH_BLOCK: begin
        // Source address is never consulted here
        final_map = acl_hit ? acl_map : 5'h00; // see RULE10 see RULE11
      end
      SFFPA_AUTH_TRAP: begin
        final_map = acl_hit ? acl_map : SFFPA_CPU_MAP; // see RULE13 see RULE14
        to_cpu = !acl_hit;
      end
      default: begin
        // Pass and the undefined code are both forced-authorised
        final_map = acl_hit ? acl_map : base_map; // see RULE8 see RULE9 see RULE22
      end
    endcase
    if (is_auth) begin
      final_map = SFFPA_CPU_MAP; // see RULE7
      to_cpu = 1'b1;
    end
    // Egress filter on own source address, same for all ports
    self_src = gc_q[3][SFFPA_BIT_SELF_EN]
               && frame_in.sa == {mac_q[0], mac_q[1], mac_q[2], mac_q[3], mac_q[4], mac_q[5]};
    if (self_src) begin
      final_map = 5'h00; // see RULE1
      to_cpu = 1'b0;
    end
    dec_d.valid = frame_in.valid;
    dec_d.fwd_map = frame_in.valid ? final_map : 5'h00;
    dec_d.to_cpu = frame_in.valid && to_cpu;
    dec_d.acl_hit = frame_in.valid && acl_hit;
  end

  // Decision register, one cycle after the summary
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d;
    end
  end

  assign decision = dec_q;

  // Checks on the registered decision against the frame one cycle earlier, and on read data
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  self_drop_a: assert property ($past(frame_in.valid) && $past(self_src)
    |-> decision.fwd_map == 5'h00) else $error("own-source frame not dropped"); // see RULE1
  uu_map_a: assert property (frame_in.valid && frame_in.unknown_uc && !frame_in.unknown_mc
    && !frame_in.unknown_vid && !frame_in.unknown_ipmc && gc_q[0][SFFPA_BIT_FILT_EN]
    && !is_auth && !self_src && mode != SFFPA_AUTH_BLOCK && mode != SFFPA_AUTH_TRAP
    && !acl_hit |=> decision.fwd_map == $past(gc_q[0][4:0]))
    else $error("unknown unicast map not applied"); // see RULE2
  vid_map_a: assert property (frame_in.valid && frame_in.unknown_vid
    && gc_q[2][SFFPA_BIT_FILT_EN] && !is_auth && !self_src && !acl_hit
    && (mode == SFFPA_AUTH_PASS || mode == SFFPA_AUTH_UNDEF)
    |=> decision.fwd_map == $past(gc_q[2][4:0])) else $error("unknown VID map wrong"); // see RULE4
  flood_a: assert property (frame_in.valid && !frame_in.unknown_uc && !frame_in.unknown_mc
    && !frame_in.unknown_vid && !frame_in.unknown_ipmc && !is_auth && !self_src
    && !acl_hit && mode != SFFPA_AUTH_BLOCK && mode != SFFPA_AUTH_TRAP
    |=> decision.fwd_map == $past(frame_in.lookup_map)) else $error("normal map altered"); // see RULE8
  auth_cpu_a: assert property (frame_in.valid && is_auth && !self_src
    |=> decision.fwd_map == SFFPA_CPU_MAP && decision.to_cpu)
    else $error("authentication frame not sent to CPU"); // see RULE7
  block_drop_a: assert property (frame_in.valid && mode == SFFPA_AUTH_BLOCK && !acl_hit
    && !is_auth |=> decision.fwd_map == 5'h00) else $error("blocked port leaked"); // see RULE10
  trap_cpu_a: assert property (frame_in.valid && mode == SFFPA_AUTH_TRAP && !acl_hit
    && !self_src |=> decision.fwd_map == SFFPA_CPU_MAP) else $error("trap miss not at CPU"); // see RULE14
  acl_gate_a: assert property (decision.acl_hit |-> $past(port_acl_en) && $past(acl_any))
    else $error("ACL hit without enable"); // see RULE11
  idle_a: assert property (!decision.valid |-> decision.fwd_map == 5'h00 && !decision.to_cpu)
    else $error("decision without frame"); // see RULE18
  rd_a: assert property (reg_rd && reg_addr == SFFPA_OFS_RSV_PAGE && !reg_wr
    |=> reg_rdata == $past(rsv_page_q)) else $error("read data wrong"); // see RULE15
  // Read data stands only in the cycle after a read strobe
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) // see RULE15
    else $error("read data outside its cycle");
  // A source outside the port range never takes an ACL action
  off_port_a: assert property (frame_in.valid // see RULE15
    && frame_in.src_port >= 3'(SFFPA_PORTS) |=> !decision.acl_hit)
    else $error("ACL hit on unmapped port");
  // The CPU flag never travels without the CPU map
  cpu_flag_a: assert property (decision.to_cpu // see RULE13
    |-> decision.fwd_map == SFFPA_CPU_MAP) else $error("CPU flag without CPU map");
  // Trap without ACL sends every frame not carrying the own source address to the CPU
  trap_all_a: assert property (frame_in.valid && mode == SFFPA_AUTH_TRAP // see RULE13
    && !port_acl_en && !self_src
    |=> decision.fwd_map == SFFPA_CPU_MAP && decision.to_cpu)
    else $error("trap port frame not at CPU");
  // Entry 0, when disabled, never hits, whatever its compare sense
  rule_off_a: assert property (rule_q[0][1:0] == 2'b00 |-> !rule_hit[0]) // see RULE19
    else $error("disabled entry hit");
  // The replace, OR and AND map modes of the winning action, on any auth mode
  acl_replace_a: assert property (frame_in.valid && acl_hit && act_mm == 2'b11 // see RULE9
    && !is_auth && !self_src |=> decision.fwd_map == $past(act_fwd))
    else $error("replace action not applied");
  acl_or_a: assert property (frame_in.valid && acl_hit && act_mm == 2'b01 // see RULE18
    && !is_auth && !self_src |=> decision.fwd_map == ($past(base_map) | $past(act_fwd)))
    else $error("OR action not applied");
  acl_and_a: assert property (frame_in.valid && acl_hit && act_mm == 2'b10 // see RULE18
    && !is_auth && !self_src |=> decision.fwd_map == ($past(base_map) & $past(act_fwd)))
    else $error("AND action not applied");

  trap_cov: cover property (frame_in.valid && mode == SFFPA_AUTH_TRAP ##1 decision.to_cpu);
  acl_cov: cover property (frame_in.valid && acl_hit && mode == SFFPA_AUTH_BLOCK);
  auth_cov: cover property (frame_in.valid && is_auth ##1 decision.valid);
  self_cov: cover property (frame_in.valid && self_src);
  or_cov: cover property (frame_in.valid && acl_hit && act_mm == 2'b01);
endmodule : sffpa_top

// ### dv/sffpa_frame_src.sv
/*
  Far-side model: the parser and lookup engine that hand one frame summary
  a cycle to the filter. Assumes the bench raises send for exactly one cycle.
*/
`timescale 1ns/1ps
module sffpa_frame_src
  import sffpa_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic send,
  input wire sffpa_frame_type want,
  output sffpa_frame_type frame_in
);
  logic [7:0] churn_q;
  logic [231:0] fill;

  // Free-running pattern, so a stale summary never looks like a held frame
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      churn_q <= 8'h00;
    end else begin
      churn_q <= churn_q + 8'h01;
    end
  end

  // Frame is present only in its own cycle; fields churn in between
  always_comb begin
    fill = {29{churn_q}};
    if (send) begin
      frame_in = want;
      frame_in.valid = 1'b1;
    end else begin
      frame_in = fill[$bits(sffpa_frame_type)-1:0];
      frame_in.valid = 1'b0;
    end
  end
endmodule : sffpa_frame_src

// ### dv/switch_frame_filter_and_port_auth_bench.sv
/*
  Self-checking bench for the frame filter: register tasks on the byte
  port, frame tasks through the far-side model. Assumes one 10 MHz clock.
*/
`timescale 1ns/1ps
module switch_frame_filter_and_port_auth_bench;
  import sffpa_pkg::*;
  localparam logic [47:0] UC_DA = 48'h020000000001;
  localparam logic [47:0] SELF = 48'h02AABBCCDDEE;
  localparam logic [47:0] HIT_SA = 48'h02000000BEEF;
  logic clock, reset_n, reg_wr, reg_rd, send;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] lay [4];
  sffpa_frame_type want, frame_in;
  sffpa_decision_type decision;
  int err_count, n_checks;
  int cycles = 0;

  sffpa_top dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_in(frame_in), .decision(decision));
  sffpa_frame_src far_end (.clock(clock), .reset_n(reset_n), .send(send),
    .want(want), .frame_in(frame_in));

  // Clock at 100 ns
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_dec(input sffpa_decision_type got, input sffpa_decision_type exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_dec

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    cmp_byte(reg_rdata, exp);
  endtask : reg_check

  task automatic rule_write(input logic [3:0] idx, input logic [63:0] bytes);
    for (int b = 0; b < 8; b++) begin
      reg_write(SFFPA_OFS_RULE_BASE + {1'b0, idx, 3'b000} + 8'(b), bytes[8*b +: 8]);
    end
  endtask : rule_write

  // Low SA bits also feed ethertype, IP and L4 fields so one value hits every layer
  task automatic frame_check(input logic [2:0] src, input logic [47:0] da,
    input logic [47:0] sa, input logic [3:0] fl, input logic [6:0] exp);
    sffpa_frame_type f;
    f = '0;
    f.src_port = src;
    f.da = da;
    f.sa = sa;
    f.ethertype = sa[15:0];
    f.ip_dst = {16'h0000, sa[15:0]};
    f.l4_dst = sa[15:0];
    {f.unknown_ipmc, f.unknown_vid, f.unknown_mc, f.unknown_uc} = fl;
    f.lookup_map = 5'h0B;
    @(posedge clock);
    want <= f;
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    @(negedge clock);
    cmp_dec(decision, {1'b1, exp});
  endtask : frame_check

  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    send = 1'b0;
    want = '0;
    err_count = 0;
    n_checks = 0;
    lay = '{8'h31, 8'h29, 8'h22, 8'h2B};
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    // Reset values, unmapped read and the narrow port control field
    for (int k = 0; k < 4; k++) reg_check(SFFPA_OFS_GC15 + 8'(k), 8'h1F);
    for (int k = 0; k < 6; k++) reg_check(SFFPA_OFS_MAC0 + 8'(k), 8'h00);
    reg_check(SFFPA_OFS_RSV_PAGE, 8'h00);
    reg_check(8'h40, 8'h00);
    reg_write(8'h21, 8'hFF);
    reg_check(8'h21, 8'h07);
    // Each unknown class: flood when off, own map when on, same on ports 0 and 2
    for (int k = 0; k < 4; k++) begin
      frame_check(3'd0, UC_DA, HIT_SA, 4'(1 << k), {5'h0B, 2'b00});
      reg_write(SFFPA_OFS_GC15 + 8'(k), 8'h20 | 8'(k + 3));
      frame_check(3'd0, UC_DA, HIT_SA, 4'(1 << k), {5'(k + 3), 2'b00});
      frame_check(3'd2, UC_DA, HIT_SA, 4'(1 << k), {5'(k + 3), 2'b00});
      reg_write(SFFPA_OFS_GC15 + 8'(k), 8'h1F);
    end
    // Authentication modes on port 1, port 2 left in pass
    reg_write(8'h21, 8'h01);
    frame_check(3'd1, UC_DA, HIT_SA, 4'h0, 7'h00);
    frame_check(3'd2, UC_DA, HIT_SA, 4'h0, {5'h0B, 2'b00});
    frame_check(3'd1, SFFPA_EAPOL_DA, HIT_SA, 4'h0, {SFFPA_CPU_MAP, 2'b10});
    reg_write(SFFPA_OFS_RSV_PAGE, 8'h05);
    frame_check(3'd1, 48'h0180C2000503, HIT_SA, 4'h0, {SFFPA_CPU_MAP, 2'b10});
    reg_write(8'h21, 8'h03);
    frame_check(3'd1, UC_DA, HIT_SA, 4'h0, {SFFPA_CPU_MAP, 2'b10});
    reg_write(8'h21, 8'h02);
    frame_check(3'd1, UC_DA, HIT_SA, 4'h0, {5'h0B, 2'b00});
    reg_write(8'h21, 8'h00);
    frame_check(3'd1, UC_DA, HIT_SA, 4'h0, {5'h0B, 2'b00});
    // Own-address filter drops the whole map
    for (int k = 0; k < 6; k++) reg_write(SFFPA_OFS_MAC0 + 8'(k), SELF[47-8*k -: 8]);
    reg_write(SFFPA_OFS_GC18, 8'h5F);
    frame_check(3'd0, UC_DA, SELF, 4'h0, 7'h00);
    frame_check(3'd0, UC_DA, HIT_SA, 4'h0, {5'h0B, 2'b00});
    reg_write(SFFPA_OFS_GC18, 8'h1F);
    // Two single-rule sets on the same value, rule 0 ahead of rule 1
    rule_write(4'd0, 64'h00000100_64BEEF31);
    rule_write(4'd1, 64'h00000201_62BEEF31);
    reg_write(8'h23, 8'h05);
    frame_check(3'd3, UC_DA, HIT_SA, 4'h0, {5'h04, 2'b01});
    frame_check(3'd3, UC_DA, SELF, 4'h0, 7'h00);
    reg_write(8'h23, 8'h07);
    frame_check(3'd3, UC_DA, SELF, 4'h0, {SFFPA_CPU_MAP, 2'b10});
    frame_check(3'd3, UC_DA, HIT_SA, 4'h0, {5'h04, 2'b01});
    reg_write(8'h23, 8'h04);
    frame_check(3'd3, UC_DA, SELF, 4'h0, {5'h0B, 2'b00});
    frame_check(3'd3, UC_DA, HIT_SA, 4'h0, {5'h04, 2'b01});
    reg_write(8'h80, 8'h30);
    // Rule 0 off; rule 1 tries each matching layer in turn
    for (int k = 0; k < 4; k++) begin
      reg_write(8'h88, lay[k]);
      frame_check(3'd3, UC_DA, HIT_SA, 4'h0, {5'h02, 2'b01});
    end
    // Map modes OR, AND and none on the lone winning set
    reg_write(8'h8B, 8'h24);
    frame_check(3'd3, UC_DA, HIT_SA, 4'h0, {5'h0F, 2'b01});
    reg_write(8'h8B, 8'h44);
    frame_check(3'd3, UC_DA, HIT_SA, 4'h0, 7'h01);
    reg_write(8'h8B, 8'h04);
    frame_check(3'd3, UC_DA, HIT_SA, 4'h0, {5'h0B, 2'b01});
    frame_check(3'd6, UC_DA, HIT_SA, 4'h0, {5'h0B, 2'b00});
    // Two-member set whose disabled member can never match
    reg_write(8'h8D, 8'h03);
    frame_check(3'd3, UC_DA, HIT_SA, 4'h0, {5'h0B, 2'b00});
    tally_and_finish();
  end
endmodule : switch_frame_filter_and_port_auth_bench
